// ### design/dpr_consts.svh
// Offsets, field positions, widths and reset values of the port block
`ifndef DPR_CONSTS_SVH
`define DPR_CONSTS_SVH
`define DPR_ADDR_W 8
`define DPR_NLINE 48
`define DPR_NNIB 12
`define DPR_NBYTE 6
`define DPR_LANES 4
`define DPR_ID_W 4
`define DPR_OFS_OUT_LO 8'h00
`define DPR_OFS_OUT_HI 8'h04
`define DPR_OFS_DIR 8'h08
`define DPR_OFS_STATUS 8'h0c
`define DPR_OFS_EFFDIR 8'h10
`define DPR_OFS_IN_LO 8'h14
`define DPR_OFS_IN_HI 8'h18
`define DPR_STAT_RET_BIT 12
`define DPR_STAT_ID_LSB 16
`define DPR_DIR_RST 12'h000
`define DPR_OUT_RST 48'h000000000000
`define DPR_SYNC_W 66
`define DPR_SYNC_RST 66'h0
`endif

// ### design/dpr_pkg.sv
// Types shared by the port configuration and retention block
package dpr_pkg;
  typedef logic [11:0] dpr_nib_t;
  typedef logic [47:0] dpr_word_t;
  typedef logic [3:0] dpr_id_t;
endpackage

// ### design/dpr_ret_if.sv
// Live and kept port state passed to the retention store
`timescale 1ns/1ps
interface dpr_ret_if;
  import dpr_pkg::*;
  logic capture;
  dpr_nib_t live_dir;
  dpr_word_t live_out;
  dpr_nib_t kept_dir;
  dpr_word_t kept_out;
  modport ctrl (output capture, output live_dir, output live_out,
    input kept_dir, input kept_out);
  modport store (input capture, input live_dir, input live_out,
    output kept_dir, output kept_out);
endinterface

// ### design/dpr_retain_store.sv
// Retention store cleared only by power-on reset
`timescale 1ns/1ps
`include "dpr_consts.svh"
module dpr_retain_store
  import dpr_pkg::*;
(
  // Clock and power-on reset
  input wire logic pclk,
  input wire logic presetn,
  // Port state
  dpr_ret_if.store ret
);
  dpr_nib_t dir_reg;
  dpr_word_t out_reg;

  // Follow live state outside warm reset, freeze during it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_reg <= `DPR_DIR_RST;
      out_reg <= `DPR_OUT_RST;
    end else if (ret.capture) begin
      dir_reg <= ret.live_dir;
      out_reg <= ret.live_out;
    end
  end

  assign ret.kept_dir = dir_reg;
  assign ret.kept_out = out_reg;
endmodule

// ### design/dpr_port_config_retention.sv
// Digital port direction, output latches, straps and warm-reset retention
`timescale 1ns/1ps
`include "dpr_consts.svh"
module dpr_port_config_retention
  import dpr_pkg::*;
(
  // Clock and power-on reset
  input wire logic pclk,
  input wire logic presetn,
  // Warm reset pin, active low
  input wire logic warm_rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`DPR_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Straps and switch
  input wire logic warm_reset_retention_strap,
  input wire logic [3:0] board_identifier_switch,
  input wire logic port_zero_low_nibble_output_strap,
  input wire logic port_zero_high_nibble_output_strap,
  input wire logic port_one_low_nibble_output_strap,
  input wire logic port_one_high_nibble_output_strap,
  input wire logic port_two_low_nibble_output_strap,
  input wire logic port_two_high_nibble_output_strap,
  input wire logic port_three_low_nibble_output_strap,
  input wire logic port_three_high_nibble_output_strap,
  input wire logic port_four_low_nibble_output_strap,
  input wire logic port_four_high_nibble_output_strap,
  input wire logic port_five_low_nibble_output_strap,
  input wire logic port_five_high_nibble_output_strap,
  // Digital lines
  input wire logic [`DPR_NLINE-1:0] pin_in,
  output logic [`DPR_NLINE-1:0] pin_out,
  output logic [`DPR_NLINE-1:0] pin_oe
);
  dpr_ret_if ret ();

  logic [`DPR_SYNC_W-1:0] sync1_reg;
  logic [`DPR_SYNC_W-1:0] sync2_reg;
  logic [`DPR_SYNC_W-1:0] raw;
  dpr_nib_t strap_raw;
  dpr_nib_t forced;
  dpr_nib_t eff_dir;
  dpr_word_t line_in;
  dpr_id_t board_id;
  logic retain_en;
  logic warm_act;
  dpr_nib_t dir_reg;
  dpr_nib_t dir_next;
  dpr_word_t out_reg;
  dpr_word_t out_next;
  dpr_word_t out_wr;
  dpr_word_t oe_next;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic setup;
  logic hit;
  logic wr_en;
  logic sel_out_lo;
  logic sel_out_hi;
  logic sel_dir;
  logic sel_status;
  logic sel_effdir;
  logic sel_in_lo;
  logic sel_in_hi;
  logic dir_wr;
  logic [31:0] status_word;

  // Straps gathered as one nibble vector, bit 2p low and 2p+1 high
  assign strap_raw = {
    port_five_high_nibble_output_strap, port_five_low_nibble_output_strap,
    port_four_high_nibble_output_strap, port_four_low_nibble_output_strap,
    port_three_high_nibble_output_strap, port_three_low_nibble_output_strap,
    port_two_high_nibble_output_strap, port_two_low_nibble_output_strap,
    port_one_high_nibble_output_strap, port_one_low_nibble_output_strap,
    port_zero_high_nibble_output_strap, port_zero_low_nibble_output_strap};
  assign raw = {warm_rst_n, warm_reset_retention_strap,
    board_identifier_switch, strap_raw, pin_in};

  // Two-flop synchroniser for every pin input
  // Flops clear to zero: warm reset looks active for two cycles after
  // power-on, with the strap read as off, so defaults load then
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_reg <= `DPR_SYNC_RST;
      sync2_reg <= `DPR_SYNC_RST;
    end else begin
      sync1_reg <= raw;
      sync2_reg <= sync1_reg;
    end
  end

  // Synchronised fields
  assign line_in = sync2_reg[`DPR_NLINE-1:0];
  assign forced = sync2_reg[`DPR_NLINE+:`DPR_NNIB];
  assign board_id = ~sync2_reg[`DPR_NLINE+`DPR_NNIB+:`DPR_ID_W];
  assign retain_en = sync2_reg[`DPR_SYNC_W-2];
  assign warm_act = ~sync2_reg[`DPR_SYNC_W-1];

  // Strap forces output, otherwise software choice
  assign eff_dir = dir_reg | forced;

  // APB decode
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pready_reg & pwrite & ~pslverr;
  assign sel_out_lo = (paddr == `DPR_OFS_OUT_LO);
  assign sel_out_hi = (paddr == `DPR_OFS_OUT_HI);
  assign sel_dir = (paddr == `DPR_OFS_DIR);
  assign sel_status = (paddr == `DPR_OFS_STATUS);
  assign sel_effdir = (paddr == `DPR_OFS_EFFDIR);
  assign sel_in_lo = (paddr == `DPR_OFS_IN_LO);
  assign sel_in_hi = (paddr == `DPR_OFS_IN_HI);
  assign hit = sel_out_lo | sel_out_hi | sel_dir | sel_status |
    sel_effdir | sel_in_lo | sel_in_hi;

  // Direction write needs both low byte lanes, the field spans them
  assign dir_wr = wr_en & sel_dir & pstrb[0] & pstrb[1];

  // Status word: forced nibbles, retention strap, board identifier
  assign status_word = {20'h00000, forced} |
    (32'(retain_en) << `DPR_STAT_RET_BIT) |
    (32'(board_id) << `DPR_STAT_ID_LSB);

  // Read data selection, unused bits zero
  assign prdata_next =
    ({32{sel_out_lo}} & out_reg[31:0]) |
    ({32{sel_out_hi}} & {16'h0000, out_reg[47:32]}) |
    ({32{sel_dir}} & {20'h00000, dir_reg}) |
    ({32{sel_status}} & status_word) |
    ({32{sel_effdir}} & {20'h00000, eff_dir}) |
    ({32{sel_in_lo}} & line_in[31:0]) |
    ({32{sel_in_hi}} & {16'h0000, line_in[47:32]});

  // Byte-lane writes to the output latches, one per byte
  genvar gb;
  generate
    for (gb = 0; gb < `DPR_NBYTE; gb = gb + 1) begin : g_byte
      localparam int LANE = gb % `DPR_LANES;
      logic lane_wr;
      assign lane_wr = wr_en & pstrb[LANE] &
        ((gb < `DPR_LANES) ? sel_out_lo : sel_out_hi);
      assign out_wr[gb*8+:8] = lane_wr ? pwdata[LANE*8+:8] :
        out_reg[gb*8+:8];
    end
  endgenerate

  // Warm reset reloads kept state or defaults; else software writes
  // A write that meets a warm reset loses to the reload and is dropped
  assign out_next = warm_act ? (retain_en ? ret.kept_out :
    `DPR_OUT_RST) : out_wr;
  assign dir_next = warm_act ? (retain_en ? ret.kept_dir :
    `DPR_DIR_RST) :
    (dir_wr ?
    pwdata[`DPR_NNIB-1:0] : dir_reg);

  // Nibble direction expanded to line enables
  genvar gn;
  generate
    for (gn = 0; gn < `DPR_NNIB; gn = gn + 1) begin : g_nib
      assign oe_next[gn*4+:4] = {4{eff_dir[gn]}};
    end
  endgenerate

  // Port state and pin drivers; power-on gives input and low latches
  // Pins lag the registers one cycle so each output leaves a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_reg <= `DPR_DIR_RST;
      out_reg <= `DPR_OUT_RST;
      pin_out <= `DPR_OUT_RST;
      pin_oe <= `DPR_OUT_RST;
    end else begin
      dir_reg <= dir_next;
      out_reg <= out_next;
      pin_out <= out_reg;
      pin_oe <= oe_next;
    end
  end

  // Retention store follows port state outside warm reset; it takes the
  // next value so a write landing as the reset arrives is kept as well
  assign ret.capture = ~warm_act;
  assign ret.live_dir = dir_next;
  assign ret.live_out = out_next;

  dpr_retain_store u_store (
    .pclk(pclk),
    .presetn(presetn),
    .ret(ret)
  );

  // APB answer: one access cycle, error on unmapped address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready_reg <= setup;
      pslverr <= setup & ~hit;
      prdata <= (setup & ~pwrite) ? prdata_next : 32'h00000000;
    end
  end

  // Ready comes straight from its flop
  assign pready = pready_reg;
endmodule

// ### bench/dpr_ext_model.sv
// Outside devices on the digital lines
`timescale 1ns/1ps
module dpr_ext_model (
  // Block side
  input wire logic [47:0] pin_out,
  input wire logic [47:0] pin_oe,
  // Device pattern
  input wire logic [47:0] ext_val,
  output logic [47:0] pin_in
);
  // Driven lines read back, the rest follow the devices
  assign pin_in = (pin_out & pin_oe) | (ext_val & ~pin_oe);
endmodule

// ### bench/dpr_port_config_retention_chk.sv
// Checker of answers, straps and resets
`timescale 1ns/1ps
module dpr_port_config_retention_chk (
  // Clock and resets
  input wire logic pclk,
  input wire logic presetn,
  input wire logic warm_rst_n,
  // Bus and straps
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] prdata,
  input wire logic warm_reset_retention_strap,
  input wire logic port_zero_low_nibble_output_strap,
  // Lines
  input wire logic [47:0] pin_out,
  input wire logic [47:0] pin_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Warm reset held with and without retention
  wire keep = !warm_rst_n && warm_reset_retention_strap;
  wire wipe = !warm_rst_n && !warm_reset_retention_strap;
  a_rdy_one: assert property (pready |=> !pready) else $error("long");
  a_rdy_setup: assert property (psel && !penable |=> pready)
    else $error("no answer");
  a_err_rdy: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("bad error");
  a_oe_forced: assert property (
    port_zero_low_nibble_output_strap[*5] |=> pin_oe[3:0] == 4'hf)
    else $error("strap lost");
  a_oe_nibble: assert property (pin_oe[47:44] inside {4'h0, 4'hf})
    else $error("split");
  a_por_clear: assert property ($rose(presetn) |-> pin_out == 48'h0)
    else $error("dirty");
  a_warm_keep: assert property (
    keep[*4] |=> $stable(pin_out) && $stable(pin_oe)) else $error("lost");
  a_warm_zero: assert property (wipe[*4] |=> pin_out == 48'h0)
    else $error("kept");
  c_keep: cover property (keep[*4]);
  c_wipe: cover property (wipe[*4]);
  c_err: cover property (pslverr);
endmodule
bind dpr_port_config_retention dpr_port_config_retention_chk i_chk (
  .pclk(pclk), .presetn(presetn), .warm_rst_n(warm_rst_n), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .prdata(prdata),
  .warm_reset_retention_strap(warm_reset_retention_strap),
  .port_zero_low_nibble_output_strap(port_zero_low_nibble_output_strap),
  .pin_out(pin_out), .pin_oe(pin_oe));

// ### bench/dpr_port_config_retention_tb.sv
// Bench of the port block
`timescale 1ns/1ps
module dpr_port_config_retention_tb;
  logic pclk = 0, presetn = 0, warm_rst_n = 1, psel = 0, penable = 0;
  logic pwrite = 0, ret = 1, pready, pslverr;
  logic [7:0] paddr = 8'h0;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic [3:0] sw = 4'h0, strb = 4'hf;
  logic [11:0] s = 12'h001;
  logic [47:0] pin_in, pin_out, pin_oe, ext = 48'h0;
  logic [32:0] e, exp_q[$];
  integer n_errors = 0, checks = 0, cyc = 0, seed = 64;
  always #2.5 pclk = ~pclk;
  dpr_port_config_retention i_dpr_port_config_retention (.pclk(pclk),
    .presetn(presetn), .warm_rst_n(warm_rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(strb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .warm_reset_retention_strap(ret), .board_identifier_switch(sw),
    .port_zero_low_nibble_output_strap(s[0]),
    .port_zero_high_nibble_output_strap(s[1]),
    .port_one_low_nibble_output_strap(s[2]),
    .port_one_high_nibble_output_strap(s[3]),
    .port_two_low_nibble_output_strap(s[4]),
    .port_two_high_nibble_output_strap(s[5]),
    .port_three_low_nibble_output_strap(s[6]),
    .port_three_high_nibble_output_strap(s[7]),
    .port_four_low_nibble_output_strap(s[8]),
    .port_four_high_nibble_output_strap(s[9]),
    .port_five_low_nibble_output_strap(s[10]),
    .port_five_high_nibble_output_strap(s[11]),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe));
  dpr_ext_model i_dpr_ext_model (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_val(ext), .pin_in(pin_in));
  // One bus transfer; reads leave their expected answer in the queue
  task automatic xfer(input int w, input logic [7:0] a,
      input logic [31:0] wd, input logic [32:0] x = 33'h0);
    if (w == 0) exp_q.push_back(x);
    psel <= 1;
    pwrite <= w[0];
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task automatic chk(input string n, input logic [47:0] x, g);
    checks++;
    if (g !== x) begin
      $display("Error %s expected %h seen %h", n, x, g);
      n_errors++;
    end
  endtask
  task automatic end_of_test;
    if (exp_q.size() != 0) n_errors++;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Read answers against the oldest note, plus the hang limit
  always @(posedge pclk) begin
    cyc++;
    if (pready === 1'b1 && !pwrite) begin
      e = exp_q.pop_front();
      checks++;
      if ({pslverr, prdata} !== e) begin
        $display("Error read expected %h seen %h", e, {pslverr, prdata});
        n_errors++;
      end
    end
    if (cyc == 5000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1;
    ext <= 48'({$random(seed), $random(seed)});
    d = $random(seed);
    repeat (6) @(posedge pclk);
    for (int i = 0; i < 16; i++) begin
      sw <= i[3:0];
      repeat (3) @(posedge pclk);
      xfer(0, 8'h0c, 0, {13'h0, ~i[3:0], 3'h0, ret, s});
    end
    xfer(1, 8'h08, 32'h2);
    xfer(1, 8'h00, d);
    xfer(0, 8'h10, 0, 33'h3);
    xfer(0, 8'h14, 0, {1'b0, ext[31:8], d[7:0]});
    xfer(0, 8'h1c, 0, 33'h100000000);
    chk("oe", 48'hff, pin_oe);
    // Direction write needs both low lanes; output writes go per lane
    strb <= 4'h1;
    xfer(1, 8'h08, 32'hfff);
    strb <= 4'h2;
    xfer(1, 8'h00, 32'h0000a500);
    strb <= 4'hf;
    xfer(0, 8'h08, 0, 33'h2);
    xfer(0, 8'h00, 0, {1'b0, d[31:16], 8'ha5, d[7:0]});
    // Warm reset kept; a write while it lasts is dropped
    warm_rst_n <= 0;
    repeat (3) @(posedge pclk);
    xfer(1, 8'h00, 0);
    warm_rst_n <= 1;
    repeat (4) @(posedge pclk);
    chk("keep", {16'h0, d[31:16], 8'ha5, d[7:0]}, pin_out);
    xfer(0, 8'h08, 0, 33'h2);
    // Warm reset without retention
    ret <= 0;
    repeat (3) @(posedge pclk);
    warm_rst_n <= 0;
    repeat (6) @(posedge pclk);
    warm_rst_n <= 1;
    repeat (4) @(posedge pclk);
    chk("wipe", 48'hf, pin_oe);
    xfer(0, 8'h08, 0);
    // Power loss clears what retention kept
    ret <= 1;
    xfer(1, 8'h08, 32'hfff);
    xfer(1, 8'h04, d);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    repeat (6) @(posedge pclk);
    xfer(0, 8'h08, 0);
    chk("power", 48'h0, pin_out);
    end_of_test();
  end
endmodule
